// file: design/adc_settle_convert_control.sv
// Purpose: Settle and convert sequencing with register readout.
// Assumes: Register port on mclk; converter code and range jumper are pins.
// Notes: Settling of a new channel may overlap a running conversion.
//
// How it works
// - Settle and convert bits act only in the write that sets them.
// - A new settle may start while the previous conversion still runs.
// - Short-settle bit selects a shorter settling count.
// - All settle and convert timing comes from internal counters.
// - Result sits at offset 04, sixteen bits, writes ignored.
// - Twelve-bit code is right-justified in the result.
// - Upper four bits are zero, or sign copies in two's complement.
// - Coding follows range jumper and active-low signed bit.
// - Status shows settle busy bit 6, convert busy 13, new data 15.
// - Strobes, mode and channel are all taken in one control write.
// - Reading the result clears the new-data flag.
// - Settle strobe is ignored while settling is busy.
// - Convert busy holds until next result; settling waits on it.
// - Channel field bits 3 to 0 picks one of sixteen inputs.
`timescale 1ns/1ns
module adc_settle_convert_control (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  input wire logic [11:0] adc_code,
  input wire logic range_bipolar,
  output logic [3:0] mux_sel,
  output logic adc_start
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [11:0] code_s1_ff;
  logic [11:0] code_ff;
  logic bip_s1_ff;
  logic bip_ff;

  // Two flops before the converter code and jumper are used
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      code_s1_ff <= 12'h000;
      code_ff <= 12'h000;
      bip_s1_ff <= 1'b0;
      bip_ff <= 1'b0;
    end else if (ce) begin
      code_s1_ff <= adc_code;
      code_ff <= code_s1_ff;
      bip_s1_ff <= range_bipolar;
      bip_ff <= bip_s1_ff;
    end
  end

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  logic [15:0] ctrl_ff;
  logic [15:0] nxt_ctrl;
  logic wr_ctrl;
  logic rd_ctrl;
  logic rd_res;
  logic tim_clr;

  assign wr_ctrl = ce && reg_wr && (reg_addr == adc_ctl_pkg::CTRL_OFF);
  assign rd_ctrl = ce && reg_rd && (reg_addr == adc_ctl_pkg::CTRL_OFF);
  assign rd_res = ce && reg_rd && (reg_addr == adc_ctl_pkg::RESULT_OFF);
  // Soft reset level, taking a write in flight into account
  assign tim_clr = wr_ctrl ? reg_wdata[adc_ctl_pkg::SRST_BIT]
                           : ctrl_ff[adc_ctl_pkg::SRST_BIT];

  // Strobe and reserved bits are never stored
  always_comb begin
    nxt_ctrl = reg_wdata;
    nxt_ctrl[adc_ctl_pkg::SETTLE_BIT] = 1'b0;
    nxt_ctrl[adc_ctl_pkg::CONV_BIT] = 1'b0;
    nxt_ctrl[adc_ctl_pkg::RSVD7_BIT] = 1'b0;
    nxt_ctrl[adc_ctl_pkg::RSVD4_BIT] = 1'b0;
  end

  // Control register
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ctrl_ff <= adc_ctl_pkg::CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  assign mux_sel = ctrl_ff[adc_ctl_pkg::CHAN_W-1:0];

  // ----------------------------------------------------------------
  // Settle sequencer and conversion timing
  // ----------------------------------------------------------------
  adc_ctl_pkg::settle_st_t st_ff;
  adc_ctl_pkg::settle_st_t nxt_st;
  logic armed_ff;
  logic nxt_armed;
  logic settle_go;
  logic conv_arm;
  logic conv_go;
  logic settle_done;
  logic conv_busy_tm;
  logic conv_done;
  logic settle_busy;
  logic conv_flag;
  logic use_short;
  logic [adc_ctl_pkg::TIMER_W-1:0] settle_cnt;

  // Strobes count only in the accepting write
  assign settle_go = wr_ctrl && reg_wdata[adc_ctl_pkg::SETTLE_BIT] &&
                     !tim_clr && (st_ff == adc_ctl_pkg::ST_IDLE);
  assign conv_arm = wr_ctrl && reg_wdata[adc_ctl_pkg::CONV_BIT] &&
                    !tim_clr;
  // Hand over to the converter only when armed and it is free
  assign conv_go = ce && !tim_clr && (st_ff == adc_ctl_pkg::ST_HOLD) &&
                   armed_ff && !conv_busy_tm;
  assign use_short = wr_ctrl ? reg_wdata[adc_ctl_pkg::SHORT_BIT]
                             : ctrl_ff[adc_ctl_pkg::SHORT_BIT];
  assign settle_cnt = use_short ? adc_ctl_pkg::SHORT_SETTLE_CYC
                                : adc_ctl_pkg::SETTLE_CYC;
  assign settle_busy = (st_ff != adc_ctl_pkg::ST_IDLE);
  assign conv_flag = armed_ff || conv_busy_tm;

  phase_timer #(
    .W(adc_ctl_pkg::TIMER_W)
  ) u_settle_tm (
    .mclk(mclk),
    .resetn(resetn),
    .ce(ce),
    .clear(tim_clr),
    .load(settle_go),
    .count(settle_cnt),
    .busy(),
    .done(settle_done)
  );

  phase_timer #(
    .W(adc_ctl_pkg::TIMER_W)
  ) u_conv_tm (
    .mclk(mclk),
    .resetn(resetn),
    .ce(ce),
    .clear(tim_clr),
    .load(conv_go),
    .count(adc_ctl_pkg::CONV_CYC),
    .busy(conv_busy_tm),
    .done(conv_done)
  );

  // Settle state, free again once the conversion is launched
  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff)
      adc_ctl_pkg::ST_IDLE: begin
        if (settle_go) begin
          nxt_st = adc_ctl_pkg::ST_SETTLE;
        end
      end
      adc_ctl_pkg::ST_SETTLE: begin
        if (settle_done) begin
          nxt_st = adc_ctl_pkg::ST_HOLD;
        end
      end
      adc_ctl_pkg::ST_HOLD: begin
        if (conv_go) begin
          nxt_st = adc_ctl_pkg::ST_IDLE;
        end
      end
      default: nxt_st = adc_ctl_pkg::ST_IDLE;
    endcase
    if (tim_clr) begin
      nxt_st = adc_ctl_pkg::ST_IDLE;
    end
  end

  // A new arm wins over the launch that consumes the old one
  assign nxt_armed = tim_clr ? 1'b0 :
                     conv_arm ? 1'b1 :
                     conv_go ? 1'b0 : armed_ff;

  // Sequencer registers
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_ff <= adc_ctl_pkg::ST_IDLE;
      armed_ff <= 1'b0;
      adc_start <= 1'b0;
    end else if (ce) begin
      st_ff <= nxt_st;
      armed_ff <= nxt_armed;
      adc_start <= conv_go;
    end
  end

  // ----------------------------------------------------------------
  // Result formatting and readout
  // ----------------------------------------------------------------
  // Offset binary unless bipolar with signed coding selected
  function automatic logic [15:0] fmt_code(input logic [11:0] code,
                                           input logic bip,
                                           input logic twos_n);
    logic [11:0] t;
    t = code;
    if (bip && !twos_n) begin
      t = {~code[11], code[10:0]};
      fmt_code = {{4{t[11]}}, t};
    end else begin
      fmt_code = {4'h0, t};
    end
  endfunction

  logic [15:0] result_ff;
  logic new_data_ff;
  logic nxt_new_data;
  logic [15:0] status;
  logic [15:0] nxt_rdata;

  // New data set wins over a clearing read in the same cycle
  assign nxt_new_data = conv_done ? 1'b1 :
                        rd_res ? 1'b0 : new_data_ff;
  always_comb begin
    status = ctrl_ff;
    status[adc_ctl_pkg::NEWDATA_BIT] = new_data_ff;
    status[adc_ctl_pkg::CONV_BIT] = conv_flag;
    status[adc_ctl_pkg::SETTLE_BIT] = settle_busy;
  end
  assign nxt_rdata = rd_ctrl ? status :
                     rd_res ? result_ff : 16'h0000;

  // Result, flag and read data registers; writes to 04 go nowhere
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      result_ff <= adc_ctl_pkg::RESULT_RESET;
      new_data_ff <= 1'b0;
      reg_rdata <= 16'h0000;
    end else if (ce) begin
      if (conv_done) begin
        result_ff <= fmt_code(code_ff, bip_ff,
                              ctrl_ff[adc_ctl_pkg::TWOS_N_BIT]);
      end
      new_data_ff <= nxt_new_data;
      if (reg_rd) begin
        reg_rdata <= nxt_rdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  settle_accept_a: assert property (
    @(posedge mclk) disable iff (!resetn)
    settle_go |=> (st_ff == adc_ctl_pkg::ST_SETTLE)
  ) else $error("settle strobe not accepted");

  settle_ignore_a: assert property (
    @(posedge mclk) disable iff (!resetn)
    (st_ff == adc_ctl_pkg::ST_HOLD) && wr_ctrl &&
    reg_wdata[adc_ctl_pkg::SETTLE_BIT] && !tim_clr && !conv_go
    |=> (st_ff == adc_ctl_pkg::ST_HOLD)
  ) else $error("settle strobe taken while busy");

  conv_flag_a: assert property (
    @(posedge mclk) disable iff (!resetn)
    conv_arm |=> conv_flag
  ) else $error("convert busy not raised");

  settle_gate_a: assert property (
    @(posedge mclk) disable iff (!resetn)
    ce && (st_ff == adc_ctl_pkg::ST_HOLD) && !armed_ff && !conv_arm &&
    !tim_clr |=> (st_ff == adc_ctl_pkg::ST_HOLD) && !adc_start
  ) else $error("settling finished without convert busy");

  short_settle_a: assert property (
    @(posedge mclk) disable iff (!resetn || !ce)
    settle_go && use_short |=> (st_ff == adc_ctl_pkg::ST_SETTLE)[*8]
    ##[1:80] (st_ff == adc_ctl_pkg::ST_HOLD)
  ) else $error("short settling too long");

  result_fmt_a: assert property (
    @(posedge mclk) disable iff (!resetn)
    conv_done && (!bip_ff || ctrl_ff[adc_ctl_pkg::TWOS_N_BIT])
    |=> (result_ff[15:12] == 4'h0) && new_data_ff
  ) else $error("binary result upper bits not zero");

  result_sign_a: assert property (
    @(posedge mclk) disable iff (!resetn)
    conv_done && bip_ff && !ctrl_ff[adc_ctl_pkg::TWOS_N_BIT]
    |=> (result_ff[15:12] == {4{~$past(code_ff[11])}})
  ) else $error("signed result not sign extended");

  read_clear_a: assert property (
    @(posedge mclk) disable iff (!resetn)
    rd_res && !conv_done |=> !new_data_ff &&
    (reg_rdata == $past(result_ff))
  ) else $error("result read left new data set");

  result_ro_a: assert property (
    @(posedge mclk) disable iff (!resetn)
    ce && reg_wr && (reg_addr == adc_ctl_pkg::RESULT_OFF) && !conv_done
    |=> $stable(result_ff)
  ) else $error("write changed the result");

  reset_idle_a: assert property (
    @(posedge mclk)
    !resetn |-> !settle_busy && !conv_flag && !new_data_ff
  ) else $error("flags set during reset");

endmodule // adc_settle_convert_control

// file: design/phase_timer.sv
// Purpose: Down counter timing one converter phase.
// Assumes: load and clear come from logic on mclk.
// Notes: done pulses in the cycle the last count elapses.
`timescale 1ns/1ns
module phase_timer #(
  parameter int W = 9
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic clear,
  input wire logic load,
  input wire logic [W-1:0] count,
  output logic busy,
  output logic done
);

  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;

  // Busy while counting, done on the final count
  assign busy = (cnt_ff != '0);
  assign done = ce && !clear && (cnt_ff == W'(1));
  assign nxt_cnt = clear ? '0 :
                   load ? count :
                   busy ? cnt_ff - W'(1) : cnt_ff;

  // Counter register
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cnt_ff <= '0;
    end else if (ce) begin
      cnt_ff <= nxt_cnt;
    end
  end

endmodule // phase_timer

// file: include/adc_ctl_pkg.sv
// Purpose: Shared constants for the converter settle and convert control.
// Assumes: 25 MHz mclk; register offsets are byte offsets on the board bus.
// Notes: Phase times are plain defaults for the analog front end fitted.
package adc_ctl_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFF = 8'h02; // Control write, status read
  localparam logic [7:0] RESULT_OFF = 8'h04; // Conversion result, read only
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] RESULT_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Control and status bit positions
  // ----------------------------------------------------------------
  localparam int SHORT_BIT = 15; // Control: short settling
  localparam int NEWDATA_BIT = 15; // Status: result available
  localparam int CONV_BIT = 13; // Control strobe / status busy
  localparam int TWOS_N_BIT = 12; // Control: signed coding, active low
  localparam int SETTLE_BIT = 6; // Control strobe / status busy
  localparam int SRST_BIT = 5; // Control: clear all timing
  localparam int RSVD7_BIT = 7;
  localparam int RSVD4_BIT = 4;
  localparam int CODE_W = 12;
  localparam int CHAN_W = 4;

  // ----------------------------------------------------------------
  // Phase timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 40;
  localparam int SETTLE_NS = 6000;
  localparam int SHORT_SETTLE_NS = 3000;
  localparam int CONV_NS = 8000;
  localparam int TIMER_W = 9;
  // Least times, rounded up to whole cycles
  localparam logic [TIMER_W-1:0] SETTLE_CYC =
    TIMER_W'((SETTLE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [TIMER_W-1:0] SHORT_SETTLE_CYC =
    TIMER_W'((SHORT_SETTLE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [TIMER_W-1:0] CONV_CYC =
    TIMER_W'((CONV_NS + CLK_NS - 1) / CLK_NS);

  // Settling sequencer states, Gray along idle, settle, hold
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SETTLE = 2'b01,
    ST_HOLD = 2'b11
  } settle_st_t;

endpackage

// file: tb/host_model.sv
// Purpose: Host model that drives the control and result registers.
// Assumes: Requests change 2 ns after the rising edge of mclk.
// Notes: Released lines show inverted data, so stale values never match.
`timescale 1ns/1ns
module host_model (
  input wire logic mclk,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata
);
  // ------------------------------------------------------------
  // Bus cycles
  // ------------------------------------------------------------
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 16'h0000;
  end

  // One access, held up to the taking edge, then released
  task automatic acc(input logic [7:0] a, input logic w,
                     input logic [15:0] d, output logic [15:0] q);
    @(posedge mclk);
    #2;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = w;
    reg_rd = !w;
    @(posedge mclk);
    #2;
    q = reg_rdata;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask

  // Strobes, mode and channel travel in one word
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] q;
    acc(a, 1'b1, d, q);
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] q);
    acc(a, 1'b0, 16'h0000, q);
  endtask

  // ------------------------------------------------------------
  // Status polling
  // ------------------------------------------------------------
  // Bounded poll of one status bit, at most 1000 reads; a timeout is left to the later checks
  task automatic poll(input int b, input logic v);
    logic [15:0] q;
    q = ~{16{v}};
    for (int i = 0; i < 1000 && q[b] !== v; i++) begin
      rd(adc_ctl_pkg::CTRL_OFF, q);
    end
  endtask

  task automatic poll_data();
    poll(adc_ctl_pkg::NEWDATA_BIT, 1'b1);
  endtask

  task automatic poll_settle();
    poll(adc_ctl_pkg::SETTLE_BIT, 1'b0);
  endtask
endmodule // host_model

// file: tb/tb.sv
// Purpose: Self-checking bench for the settle and convert control.
// Assumes: Host model does all register cycles; bench drives the pins.
// Notes: Read results are checked against a queue by a watcher process.
`timescale 1ns/1ns
module tb;
  logic mclk, resetn, ce, reg_wr, reg_rd, range_bipolar, adc_start;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, last, ctl;
  logic [11:0] adc_code, c;
  logic [3:0] mux_sel;
  logic [31:0] q[$];
  logic chk_on, pend;
  int err_count, n_tests, seed, n, g, dly0, dly1;
  localparam logic [7:0] CA = adc_ctl_pkg::CTRL_OFF;
  localparam logic [7:0] RA = adc_ctl_pkg::RESULT_OFF;

  host_model u_host (.mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  adc_settle_convert_control dut (.mclk(mclk), .resetn(resetn), .ce(ce),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .adc_code(adc_code),
    .range_bipolar(range_bipolar), .mux_sel(mux_sel),
    .adc_start(adc_start));

  // ------------------------------------------------------------
  // Checking
  // ------------------------------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Watcher: a checked read shows its data one edge after it is taken
  always @(posedge mclk) begin
    logic [31:0] e;
    if (pend) begin
      e = q.pop_front();
      check(reg_rdata & e[31:16], e[15:0]);
    end
    pend = reg_rd && chk_on;
  end

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] m,
                        input logic [15:0] e);
    logic [15:0] d;
    q.push_back({m, e});
    chk_on = 1'b1;
    u_host.rd(a, d);
    chk_on = 1'b0;
  endtask

  // Expected result word from code, range and active-low signed bit
  function automatic logic [15:0] coded(input logic [11:0] k,
                                        input logic bip, input logic tn);
    logic [11:0] t;
    t = k ^ 12'h800;
    if (bip && !tn) return {{4{t[11]}}, t};
    return {4'h0, k};
  endfunction

  // ------------------------------------------------------------
  // Sequences
  // ------------------------------------------------------------
  task automatic arm(input logic bip);
    c = 12'($random(seed));
    adc_code = c;
    range_bipolar = bip;
  endtask

  // Edges until the convert launch pulse, at most 1000; looked at 1 ns
  // after each edge so a pulse launched there has settled
  task automatic wait_start(output int k);
    k = 0;
    do begin
      @(posedge mclk);
      #1;
      k++;
    end while (adc_start !== 1'b1 && k < 1000);
  endtask

  task automatic tail(input logic [15:0] e, input logic [15:0] st);
    u_host.poll_data();
    rd_chk(RA, 16'hFFFF, e);
    rd_chk(CA, 16'hA040, st);
    last = e;
  endtask

  task automatic conv(input logic [15:0] w, input logic bip, output int k);
    arm(bip);
    u_host.wr(CA, w);
    check(16'(mux_sel), 16'(w[3:0]));
    rd_chk(CA, 16'hA040, 16'h2040);
    wait_start(k);
    k = k + 2;
    tail(coded(c, bip, w[12]), 16'h0000);
  endtask

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // Watchdog well beyond the expected run of some 5000 cycles
  initial begin
    #800000;
    err_count++;
    final_report();
  end

  task automatic final_report();
    if (err_count == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    seed = 32'hB202B896;
    {err_count, n_tests, chk_on, pend} = '0;
    {ce, resetn, adc_code, range_bipolar} = {2'b10, 13'h0000};
    repeat (20) @(posedge mclk);
    #2 resetn = 1'b1;
    rd_chk(CA, 16'hFFFF, 16'h0000);
    rd_chk(RA, 16'hFFFF, 16'h0000);
    // Every coding, normal then short settling
    for (int i = 0; i < 6; i++) begin
      ctl = {i >= 3, 2'b01, i % 3 != 2, 5'h00, 1'b1, 2'b00,
             4'($random(seed))};
      conv(ctl, i % 3 != 0, n);
      if (i >= 3) dly1 = n;
      else dly0 = n;
    end
    check(16'(dly0 - dly1), 16'(adc_ctl_pkg::SETTLE_CYC -
          adc_ctl_pkg::SHORT_SETTLE_CYC));
    check(16'(dly0 >= adc_ctl_pkg::SETTLE_CYC), 16'h0001);
    // Result writes ignored; a word without strobes starts nothing
    u_host.wr(RA, 16'hFFFF);
    u_host.wr(CA, 16'h1005);
    wait_start(n);
    check(16'(n), 16'h03E8);
    rd_chk(CA, 16'hA040, 16'h0000);
    rd_chk(RA, 16'hFFFF, last);
    // Settling alone parks in hold until a convert strobe arrives
    u_host.wr(CA, 16'h1045);
    wait_start(n);
    check(16'(n), 16'h03E8);
    rd_chk(CA, 16'hA040, 16'h0040);
    arm(1'b1);
    u_host.wr(CA, 16'h3045);
    wait_start(n);
    check(16'(n), 16'h0001);
    tail(coded(c, 1'b1, 1'b1), 16'h0000);
    // Second settle strobe in mid-settle must not restart the timing
    arm(1'b0);
    u_host.wr(CA, 16'h2043);
    // Ten edges with the clock enable low stretch the settle by ten
    repeat (20) @(posedge mclk);
    #2 ce = 1'b0;
    repeat (10) @(posedge mclk);
    #2 ce = 1'b1;
    repeat (16) @(posedge mclk);
    u_host.wr(CA, 16'h0043);
    wait_start(g);
    check(16'(g + 38), 16'(dly0));
    tail(coded(c, 1'b0, 1'b1), 16'h0000);
    // Interleave: next channel settles while the last one converts
    arm(1'b0);
    u_host.wr(CA, 16'h2041);
    wait_start(g);
    u_host.poll_settle();
    u_host.wr(CA, 16'h2042);
    rd_chk(CA, 16'h2040, 16'h2040);
    wait_start(g);
    check(16'(g < adc_ctl_pkg::SETTLE_CYC + adc_ctl_pkg::CONV_CYC),
          16'h0001);
    tail({4'h0, c}, 16'h2000);
    arm(1'b0);
    tail({4'h0, c}, 16'h0000);
    final_report();
  end
endmodule // tb
